//--- core/uart_xf.sv
// uart extra features: rs-485 direction, multidrop receive, irda pulse, tx/rx disable
`timescale 1ns/1ps
`include "uart_xf_regs.svh"
module uart_xf (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxd_i,
  input  wire logic        hw_flow_en_i,
  input  wire logic        flow_rts_n_i,
  output logic             txd_o,
  output logic             irda_tx_o,
  output logic             rts_n_o,
  output logic             irq_o
);
  function automatic logic hit(input logic [5:0] adr, input logic [5:0] off);
    hit = (adr == off);
  endfunction

  logic [7:0]         ctrl_q, efr_q, pause2_q, mcr_q;
  logic [2:0]         ist_q, ien_q;
  logic               ack_q, rxoff_prev_q, rxd1_q, rxd2_q, tx_ready_q;
  logic [31:0]        rdat_q;
  logic [`XF_FIFO_AW-1:0] t_wp_q, t_rp_q, r_wp_q, r_rp_q;
  logic [4:0]         t_cnt_q, r_cnt_q;
  uart_xf_pkg::tx_e   tx_st_q;
  uart_xf_pkg::rx_e   rx_st_q;
  logic [3:0]         tx_tick_q, tx_bit_q, rx_tick_q, rx_bit_q;
  logic [8:0]         tx_sh_q, rx_sh_q;
  uart_xf_pkg::char_s t_rd, r_rd, t_wd, rx_wd;
  logic               tick;

  // bus slave: one wait state, write and pop happen on the acknowledged edge
  wire acc    = wb_cyc_i & wb_stb_i & ~ack_q;
  wire done   = wb_cyc_i & wb_stb_i & ack_q;
  wire wr     = done & wb_we_i & wb_sel_i[0];
  wire rd     = done & ~wb_we_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  wire md     = ctrl_q[`XF_MDROP];
  wire rxoff  = ctrl_q[`XF_RXOFF];
  wire txoff  = ctrl_q[`XF_TXOFF];
  wire scd    = efr_q[`XF_SCD];

  // transmit fifo and shifter
  wire t_full  = (t_cnt_q == `XF_FIFO_FULL);
  wire t_empty = (t_cnt_q == `XF_CNT_RST);
  wire tx_push = wr & hit(wb_adr_i, `XF_TXD) & ~t_full;
  wire tx_idle = (tx_st_q == uart_xf_pkg::TX_IDLE);
  // start only on a tick so the start bit gets its full sixteen ticks
  wire tx_load = tx_idle & tx_ready_q & ~txoff & tick;
  wire tx_bend = tick & (tx_tick_q == `XF_OS_LAST);
  wire [3:0] last_bit = md ? `XF_LAST_MD : `XF_LAST_STD;
  wire tx_done = tx_bend & (tx_st_q == uart_xf_pkg::TX_STOP);
  wire tx_busy = tx_push | ~t_empty | ~tx_idle;
  assign t_wd = '{ninth: wb_sel_i[1] & wb_dat_i[8], data: wb_dat_i[7:0]};

  // receive path
  wire r_full  = (r_cnt_q == `XF_FIFO_FULL);
  wire r_empty = (r_cnt_q == `XF_CNT_RST);
  wire rx_pop  = rd & hit(wb_adr_i, `XF_RXD) & ~r_empty;
  wire rx_idle = (rx_st_q == uart_xf_pkg::RX_IDLE);
  wire rx_bend = tick & (rx_tick_q == `XF_OS_LAST);
  wire rx_done = rx_bend & (rx_st_q == uart_xf_pkg::RX_STOP);
  wire addr    = md & rx_sh_q[8];
  wire match   = (rx_sh_q[7:0] == pause2_q);
  wire auto_hit  = rx_done & md & scd & addr & match;
  wire auto_miss = rx_done & md & scd & addr & ~match;
  // normal multidrop keeps addresses even while disabled so software can judge them
  wire keep = md ? (scd ? (addr ? match : ~rxoff) : (addr | ~rxoff)) : ~rxoff;
  wire partial = rxoff & ~rxoff_prev_q & ~md & ~rx_idle;
  wire rx_push = ((rx_done & keep) | partial) & ~r_full;
  // a cut character never counts as an address
  assign rx_wd = '{ninth: addr & ~partial, data: rx_sh_q[7:0]};
  wire rx_start = rx_idle & ~rxd2_q & (md | ~rxoff);

  // events and interrupt
  wire [2:0] ev_set;
  assign ev_set[`XF_EV_RX] = rx_push;
  assign ev_set[`XF_EV_TX] = tx_done & t_empty;
  assign ev_set[`XF_EV_LS] = rx_push & rx_wd.ninth;
  wire [2:0] ev_clr = (wr & hit(wb_adr_i, `XF_ICLR)) ? wb_dat_i[2:0] : `XF_EV_RST;

  // direction pin
  wire own_rts   = ~tx_busy ^ ctrl_q[`XF_POL];
  wire plain_rts = hw_flow_en_i ? flow_rts_n_i : ~mcr_q[`XF_MCR_RTS];
  wire rts_n_d   = ctrl_q[`XF_OWN] ? own_rts : plain_rts;

  // serial outputs
  wire txd_d = (tx_st_q == uart_xf_pkg::TX_START) ? 1'b0 :
               (tx_st_q == uart_xf_pkg::TX_DATA)  ? tx_sh_q[0] : 1'b1;
  wire [3:0] ir_len = ctrl_q[`XF_IRDA] ? `XF_IR_WIDE : `XF_IR_NARROW;
  wire irda_d = ~tx_idle & ~txd_d & (tx_tick_q < ir_len);

  wire [7:0] lstat = {1'b0, tx_idle & t_empty, t_empty, 2'b00,
                      ~r_empty & r_rd.ninth, 1'b0, ~r_empty};
  wire [31:0] rmux =
    hit(wb_adr_i, `XF_CTRL)   ? {24'h0, ctrl_q} :
    hit(wb_adr_i, `XF_EFR)    ? {24'h0, efr_q} :
    hit(wb_adr_i, `XF_PAUSE2) ? {24'h0, pause2_q} :
    hit(wb_adr_i, `XF_IEN)    ? {29'h0, ien_q} :
    hit(wb_adr_i, `XF_LSTAT)  ? {24'h0, lstat} :
    hit(wb_adr_i, `XF_MCR)    ? {24'h0, mcr_q} :
    hit(wb_adr_i, `XF_IST)    ? {29'h0, ist_q} :
    hit(wb_adr_i, `XF_RXD)    ? {23'h0, r_rd} : 32'h0;

  uart_xf_tick u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  uart_xf_mem u_tx_mem (
    .clk_i (clk_i),
    .we_i  (tx_push),
    .wa_i  (t_wp_q),
    .wd_i  (t_wd),
    .ra_i  (t_rp_q),
    .rd_o  (t_rd)
  );

  uart_xf_mem u_rx_mem (
    .clk_i (clk_i),
    .we_i  (rx_push),
    .wa_i  (r_wp_q),
    .wd_i  (rx_wd),
    .ra_i  (r_rp_q),
    .rd_o  (r_rd)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= acc;
      if (acc) begin
        rdat_q <= wb_we_i ? 32'h0 : rmux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q   <= `XF_CTRL_RST;
      efr_q    <= `XF_BYTE_RST;
      pause2_q <= `XF_BYTE_RST;
      mcr_q    <= `XF_BYTE_RST;
      ien_q    <= `XF_EV_RST;
    end else begin
      if (wr & hit(wb_adr_i, `XF_CTRL)) begin
        ctrl_q <= wb_dat_i[7:0] & `XF_CTRL_MASK;
      end
      // hardware address verdict overrides a same-cycle software write
      if (auto_hit) begin
        ctrl_q[`XF_RXOFF] <= 1'b0;
      end else if (auto_miss) begin
        ctrl_q[`XF_RXOFF] <= 1'b1;
      end
      if (wr & hit(wb_adr_i, `XF_EFR))    efr_q    <= wb_dat_i[7:0];
      if (wr & hit(wb_adr_i, `XF_PAUSE2)) pause2_q <= wb_dat_i[7:0];
      if (wr & hit(wb_adr_i, `XF_MCR))    mcr_q    <= wb_dat_i[7:0];
      if (wr & hit(wb_adr_i, `XF_IEN))    ien_q    <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q     <= `XF_EV_RST;
      irq_o     <= 1'b0;
      rts_n_o   <= 1'b1;
      txd_o     <= 1'b1;
      irda_tx_o <= 1'b0;
    end else begin
      ist_q     <= (ist_q & ~ev_clr) | ev_set;
      irq_o     <= |(ist_q & ien_q);
      rts_n_o   <= rts_n_d;
      txd_o     <= txd_d;
      irda_tx_o <= irda_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t_wp_q  <= `XF_PTR_RST;
      t_rp_q  <= `XF_PTR_RST;
      t_cnt_q <= `XF_CNT_RST;
      r_wp_q  <= `XF_PTR_RST;
      r_rp_q  <= `XF_PTR_RST;
      r_cnt_q <= `XF_CNT_RST;
    end else begin
      if (tx_push) t_wp_q <= t_wp_q + 4'h1;
      if (tx_load) t_rp_q <= t_rp_q + 4'h1;
      t_cnt_q <= t_cnt_q + {4'h0, tx_push} - {4'h0, tx_load};
      if (rx_push) r_wp_q <= r_wp_q + 4'h1;
      if (rx_pop)  r_rp_q <= r_rp_q + 4'h1;
      r_cnt_q <= r_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  // load waits one cycle after the fifo turns non-empty: the memory read is registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ready_q <= 1'b0;
      tx_st_q    <= uart_xf_pkg::TX_IDLE;
      tx_tick_q  <= 4'h0;
      tx_bit_q   <= 4'h0;
      tx_sh_q    <= 9'h1ff;
    end else begin
      tx_ready_q <= ~t_empty & tx_idle & ~tx_load;
      if (tick) tx_tick_q <= tx_tick_q + 4'h1;
      case (tx_st_q)
        uart_xf_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_st_q   <= uart_xf_pkg::TX_START;
            tx_sh_q   <= t_rd;
            tx_tick_q <= 4'h0;
          end
        end
        uart_xf_pkg::TX_START: begin
          if (tx_bend) begin
            tx_st_q  <= uart_xf_pkg::TX_DATA;
            tx_bit_q <= 4'h0;
          end
        end
        uart_xf_pkg::TX_DATA: begin
          if (tx_bend) begin
            tx_sh_q  <= {1'b1, tx_sh_q[8:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == last_bit) tx_st_q <= uart_xf_pkg::TX_STOP;
          end
        end
        uart_xf_pkg::TX_STOP: begin
          if (tx_bend) tx_st_q <= uart_xf_pkg::TX_IDLE;
        end
        default: tx_st_q <= uart_xf_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd1_q       <= 1'b1;
      rxd2_q       <= 1'b1;
      rxoff_prev_q <= 1'b0;
      rx_st_q      <= uart_xf_pkg::RX_IDLE;
      rx_tick_q    <= 4'h0;
      rx_bit_q     <= 4'h0;
      rx_sh_q      <= 9'h000;
    end else begin
      rxd1_q       <= rxd_i;
      rxd2_q       <= rxd1_q;
      rxoff_prev_q <= rxoff;
      if (tick) rx_tick_q <= rx_tick_q + 4'h1;
      case (rx_st_q)
        uart_xf_pkg::RX_IDLE: begin
          if (rx_start) begin
            rx_st_q   <= uart_xf_pkg::RX_START;
            rx_tick_q <= 4'h0;
            rx_sh_q   <= 9'h000;
          end
        end
        uart_xf_pkg::RX_START: begin
          if (tick & (rx_tick_q == `XF_OS_MID)) begin
            // realign so later samples land mid-bit; a short glitch is no start
            rx_tick_q <= 4'h0;
            rx_bit_q  <= 4'h0;
            rx_st_q   <= rxd2_q ? uart_xf_pkg::RX_IDLE : uart_xf_pkg::RX_DATA;
          end
        end
        uart_xf_pkg::RX_DATA: begin
          if (rx_bend) begin
            rx_sh_q[rx_bit_q] <= rxd2_q;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == last_bit) rx_st_q <= uart_xf_pkg::RX_STOP;
          end
        end
        uart_xf_pkg::RX_STOP: begin
          if (rx_bend) rx_st_q <= uart_xf_pkg::RX_IDLE;
        end
        default: rx_st_q <= uart_xf_pkg::RX_IDLE;
      endcase
      if (partial) rx_st_q <= uart_xf_pkg::RX_IDLE;
    end
  end

  sequence s_partial_store;
    rx_push ##1 (rx_st_q == uart_xf_pkg::RX_IDLE);
  endsequence

  sequence s_auto_off;
    !rx_push ##1 ctrl_q[`XF_RXOFF];
  endsequence

  a_ir_narrow:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (!tx_idle && tx_tick_q == `XF_IR_NARROW && !ctrl_q[`XF_IRDA]) |=> !irda_tx_o)
    else $error("irda pulse wider than 3/16");
  a_rts_invert:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`XF_OWN] && ctrl_q[`XF_POL] && !tx_idle) |=> rts_n_o)
    else $error("inverted direction pin not high while sending");
  a_rts_manual:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_q[`XF_OWN] && !hw_flow_en_i) |=> (rts_n_o == !$past(mcr_q[`XF_MCR_RTS])))
    else $error("direction pin not following modem control");
  a_rts_on_write:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[`XF_OWN] && !ctrl_q[`XF_POL] && tx_push) |=> !rts_n_o)
    else $error("direction pin not active after fifo write");
  a_txoff_holds:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_idle && txoff ##1 txoff) |-> tx_idle ##1 tx_idle)
    else $error("transmitter started while disabled");
  a_rxoff_partial:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (partial && !r_full) |-> s_partial_store)
    else $error("partial character not stored on receive off");
  a_md_discard:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_done && md && !scd && rxoff && !rx_sh_q[8]) |-> !rx_push)
    else $error("data kept while multidrop receiver disabled");
  a_md_addr_flag:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_done && md && !scd && rx_sh_q[8] && !r_full) |-> (rx_push && rx_wd.ninth)
      ##1 ist_q[`XF_EV_LS])
    else $error("address character not flagged");
  a_auto_drop:
  assert property (@(posedge clk_i) disable iff (rst_i)
    auto_miss |-> s_auto_off)
    else $error("foreign address not rejected");
  a_auto_match:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (auto_hit && !r_full) |-> rx_push && rx_wd.ninth ##1 !ctrl_q[`XF_RXOFF])
    else $error("matching address not accepted");
  a_rsv_zero:
  assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_q[`XF_RSV_HI] && !ctrl_q[`XF_RSV_LO])
    else $error("reserved control bit set");
endmodule

//--- core/uart_xf_regs.svh
// register offsets, field positions, reset values and timing counts of the extra-features block
`ifndef UART_XF_REGS_SVH
`define UART_XF_REGS_SVH
`define XF_CTRL       6'h00
`define XF_EFR        6'h04
`define XF_PAUSE2     6'h08
`define XF_IEN        6'h0c
`define XF_LSTAT      6'h10
`define XF_MCR        6'h14
`define XF_IST        6'h18
`define XF_ICLR       6'h1c
`define XF_TXD        6'h20
`define XF_RXD        6'h24
`define XF_IRDA       7
`define XF_RSV_HI     6
`define XF_POL        5
`define XF_OWN        4
`define XF_RSV_LO     3
`define XF_TXOFF      2
`define XF_RXOFF      1
`define XF_MDROP      0
`define XF_CTRL_MASK  8'hb7
`define XF_CTRL_RST   8'h00
`define XF_BYTE_RST   8'h00
`define XF_SCD        5
`define XF_MCR_RTS    1
`define XF_EV_RX      0
`define XF_EV_TX      1
`define XF_EV_LS      2
`define XF_EV_RST     3'h0
`define XF_LS_DR      0
`define XF_LS_PE      2
`define XF_LS_TE      5
`define XF_LS_TI      6
`define XF_BAUD_LAST  8'h04
`define XF_OS_LAST    4'hf
`define XF_OS_MID     4'h7
`define XF_IR_NARROW  4'h3
`define XF_IR_WIDE    4'h4
`define XF_LAST_MD    4'h8
`define XF_LAST_STD   4'h7
`define XF_FIFO_AW    4
`define XF_FIFO_FULL  5'h10
`define XF_CNT_RST    5'h00
`define XF_PTR_RST    4'h0
`endif

//--- core/uart_xf_pkg.sv
// types shared by the extra-features block and its helpers
package uart_xf_pkg;
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } char_s;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_e;
endpackage

//--- core/uart_xf_tick.sv
// sixteen-times oversampling enable pulse divided down from clk_i
`timescale 1ns/1ps
`include "uart_xf_regs.svh"
module uart_xf_tick (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [7:0] div_q;
  wire        wrap = (div_q == `XF_BAUD_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      div_q  <= wrap ? 8'h00 : div_q + 8'h01;
      tick_o <= wrap;
    end
  end
endmodule

//--- core/uart_xf_mem.sv
// character store for one fifo; read data leave through a register
`timescale 1ns/1ps
`include "uart_xf_regs.svh"
module uart_xf_mem (
  input  wire logic                    clk_i,
  input  wire logic                    we_i,
  input  wire logic [`XF_FIFO_AW-1:0]  wa_i,
  input  wire uart_xf_pkg::char_s      wd_i,
  input  wire logic [`XF_FIFO_AW-1:0]  ra_i,
  output uart_xf_pkg::char_s           rd_o
);
  uart_xf_pkg::char_s mem_q [0:(1<<`XF_FIFO_AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[wa_i] <= wd_i;
    end
    rd_o <= mem_q[ra_i];
  end
endmodule

//--- verif/uart_xf_station.sv
// far-side rs-485 station model: sends frames on request and decodes the transmit line
`timescale 1ns/1ps
module uart_xf_station (
  input  wire logic               clk_i,
  input  wire logic               go_i,
  input  wire logic               nine_i,
  input  wire uart_xf_pkg::char_s ch_i,
  input  wire logic               txd_i,
  output logic                    line_o,
  output logic                    busy_o,
  output uart_xf_pkg::char_s      got_o,
  output logic [7:0]              cnt_o
);
  localparam int BIT_CLKS = 80;
  logic [10:0]        fr;
  logic [8:0]         sh;
  int                 nb;
  // start, data lsb first, ninth bit only in multidrop, then stop; line rests at mark
  initial begin
    line_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i && !busy_o) begin
        busy_o <= 1'b1;
        fr = nine_i ? {1'b1, ch_i, 1'b0} : {2'b11, ch_i.data, 1'b0};
        nb = nine_i ? 11 : 10;
        for (int i = 0; i < nb; i++) begin
          line_o <= fr[i];
          repeat (BIT_CLKS) @(posedge clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
  // sample mid-bit; a glitch shorter than half a bit is not taken as a start
  initial begin
    got_o = '0;
    cnt_o = 8'h00;
    forever begin
      @(negedge txd_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      if (txd_i === 1'b0) begin
        sh = 9'h000;
        for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
          repeat (BIT_CLKS) @(posedge clk_i);
          sh[i] = txd_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        got_o <= sh;
        cnt_o <= cnt_o + 8'h01;
      end
    end
  end
endmodule

//--- verif/tb_top.sv
// self-checking bench for the uart extra-features block
`timescale 1ns/1ps
`include "uart_xf_regs.svh"
module tb_top;
  logic               clk_i, rst_i, cyc, stb, we, hw_fl, fl_rts_n, go, nine;
  logic [5:0]         adr;
  logic [31:0]        wdat, rdat, q;
  logic               ack, txd, irda, rts_n, irq, rxd, busy;
  uart_xf_pkg::char_s ch, got;
  logic [7:0]         cnt, c0;
  int                 n_fail, n_tests, w, k;

  uart_xf u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rxd_i(rxd), .hw_flow_en_i(hw_fl), .flow_rts_n_i(fl_rts_n),
    .txd_o(txd), .irda_tx_o(irda), .rts_n_o(rts_n), .irq_o(irq));
  uart_xf_station u_far (.clk_i(clk_i), .go_i(go), .nine_i(nine), .ch_i(ch),
    .txd_i(txd), .line_o(rxd), .busy_o(busy), .got_o(got), .cnt_o(cnt));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then release for a cycle;
  // only the watchdog ends a wait for ack
  task automatic wb(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= wr;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic send(input logic nn, input logic [7:0] d);
    @(posedge clk_i);
    ch <= {nn, d};
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    // the station raises busy on the edge that takes go; look one edge later
    @(posedge clk_i);
    while (busy === 1'b1) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
  endtask

  task automatic wait_tx;
    c0 = cnt;
    for (k = 0; cnt === c0 && k < 3000; k++) @(posedge clk_i);
    if (k >= 3000) n_fail++;
  endtask

  task automatic pulse_w;
    for (k = 0; irda !== 1'b1 && k < 2000; k++) @(posedge clk_i);
    for (w = 0; irda === 1'b1 && w < 100; w++) @(posedge clk_i);
  endtask

  initial begin
    {cyc, stb, we, go, nine, hw_fl} = 6'h00;
    {fl_rts_n, rst_i} = 2'b11;
    adr  = 6'h00;
    wdat = 32'h0;
    ch   = '0;
    n_fail  = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`XF_CTRL, 32'h0);
    wb(1'b1, `XF_CTRL, 32'hff);
    rd(`XF_CTRL, 32'hb7);
    wb(1'b1, 6'h3c, 32'hff);
    rd(6'h3c, 32'h0);
    $display("test registers done");
    // flow control asks for the pin, ownership must win
    hw_fl    <= 1'b1;
    fl_rts_n <= 1'b0;
    wb(1'b1, `XF_CTRL, 32'h10);
    repeat (3) @(posedge clk_i);
    chk(rts_n, 1'b1);
    wb(1'b1, `XF_TXD, 32'h55);
    @(posedge clk_i);
    @(negedge clk_i);
    chk(rts_n, 1'b0);
    wait_tx();
    chk(got, 32'h055);
    chk(rts_n, 1'b0);
    repeat (80) @(posedge clk_i);
    chk(rts_n, 1'b1);
    wb(1'b1, `XF_CTRL, 32'h30);
    repeat (3) @(posedge clk_i);
    chk(rts_n, 1'b0);
    wb(1'b1, `XF_TXD, 32'haa);
    @(posedge clk_i);
    @(negedge clk_i);
    chk(rts_n, 1'b1);
    wait_tx();
    repeat (80) @(posedge clk_i);
    chk(rts_n, 1'b0);
    wb(1'b1, `XF_CTRL, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(rts_n, 1'b0);
    fl_rts_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(rts_n, 1'b1);
    hw_fl <= 1'b0;
    $display("test direction done");
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, `XF_CTRL, m ? 32'h80 : 32'h00);
      wb(1'b1, `XF_TXD, 32'h00);
      pulse_w();
      chk(w, m ? 32'h14 : 32'h0f);
      wait_tx();
    end
    $display("test infrared done");
    wb(1'b1, `XF_CTRL, 32'h0);
    wb(1'b1, `XF_TXD, 32'h3c);
    for (k = 0; txd !== 1'b0 && k < 200; k++) @(posedge clk_i);
    wb(1'b1, `XF_CTRL, 32'h04);
    wb(1'b1, `XF_TXD, 32'hc3);
    wait_tx();
    chk(got, 32'h03c);
    repeat (1200) @(posedge clk_i);
    chk(cnt, c0 + 8'h01);
    wb(1'b1, `XF_CTRL, 32'h0);
    wait_tx();
    chk(got, 32'h0c3);
    // let the stop bit end so the transmit event lands before the clear below
    repeat (80) @(posedge clk_i);
    $display("test transmit off done");
    wb(1'b1, `XF_ICLR, 32'h7);
    wb(1'b1, `XF_IEN, 32'h1);
    send(1'b0, 8'ha5);
    chk(irq, 1'b1);
    rd(`XF_IST, 32'h1);
    rd(`XF_RXD, 32'h0a5);
    wb(1'b1, `XF_ICLR, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    wb(1'b1, `XF_IEN, 32'h0);
    send(1'b0, 8'h5a);
    chk(irq, 1'b0);
    rd(`XF_RXD, 32'h05a);
    $display("test receive done");
    nine <= 1'b1;
    wb(1'b1, `XF_EFR, 32'h0);
    wb(1'b1, `XF_CTRL, 32'h03);
    wb(1'b1, `XF_ICLR, 32'h7);
    wb(1'b1, `XF_IEN, 32'h4);
    send(1'b0, 8'h11);
    rd(`XF_IST, 32'h0);
    send(1'b1, 8'h42);
    chk(irq, 1'b1);
    wb(1'b0, `XF_LSTAT, 32'h0);
    chk(q & 32'h5, 32'h5);
    rd(`XF_RXD, 32'h142);
    wb(1'b1, `XF_ICLR, 32'h7);
    wb(1'b1, `XF_CTRL, 32'h01);
    send(1'b0, 8'h33);
    rd(`XF_RXD, 32'h033);
    send(1'b1, 8'h77);
    chk(irq, 1'b1);
    rd(`XF_RXD, 32'h177);
    $display("test multidrop done");
    wb(1'b1, `XF_ICLR, 32'h7);
    wb(1'b1, `XF_EFR, 32'h20);
    wb(1'b1, `XF_PAUSE2, 32'h42);
    wb(1'b1, `XF_CTRL, 32'h03);
    send(1'b0, 8'h10);
    send(1'b1, 8'h55);
    rd(`XF_IST, 32'h0);
    send(1'b1, 8'h42);
    chk(irq, 1'b1);
    rd(`XF_CTRL, 32'h01);
    rd(`XF_RXD, 32'h142);
    send(1'b0, 8'h20);
    rd(`XF_RXD, 32'h020);
    send(1'b1, 8'h42);
    rd(`XF_RXD, 32'h142);
    send(1'b1, 8'h55);
    rd(`XF_CTRL, 32'h03);
    wb(1'b1, `XF_ICLR, 32'h7);
    send(1'b0, 8'h21);
    rd(`XF_IST, 32'h0);
    $display("test address detect done");
    nine <= 1'b0;
    wb(1'b1, `XF_EFR, 32'h0);
    wb(1'b1, `XF_CTRL, 32'h0);
    wb(1'b1, `XF_ICLR, 32'h7);
    fork
      send(1'b0, 8'hff);
      begin
        repeat (400) @(posedge clk_i);
        wb(1'b1, `XF_CTRL, 32'h02);
      end
    join
    rd(`XF_IST, 32'h1);
    wb(1'b1, `XF_ICLR, 32'h7);
    send(1'b0, 8'hff);
    rd(`XF_IST, 32'h0);
    $display("test receive off done");
    wrap_up();
  end

  // whole run needs about 20000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    wrap_up();
  end
endmodule
